// ---- rtl/scu_pkg.sv ----
/*
  constants, states and carriers for the serial communication unit.
  assumes a 40 mhz system clock; the unit itself is in scu_top.sv.
*/
package scu_pkg;
  // clock and bus timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int CLK_HZ = 40_000_000;
  localparam int BAUD = 115200;
  // bus-free time, reference only: the start logic does not wait for it
  localparam int T_BUF_STD_NS = 4700;
  localparam int T_BUF_FAST_NS = 1300;
  localparam int T_HD_STA_NS = 4000;
  localparam int T_SU_STO_NS = 4000;
  localparam logic [9:0] HD_CYC = 10'((T_HD_STA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [9:0] SU_CYC = 10'((T_SU_STO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [9:0] BIT_CYC = 10'(CLK_HZ / BAUD);
  localparam logic [9:0] HALF_CYC = 10'(CLK_HZ / BAUD / 2);
  // pin synchroniser reset: {mosi, cs_b, sclk, rxd, sda, scl}
  localparam logic [5:0] SYNC_RST = 6'h37;
  localparam logic [3:0] ACK_RISE = 4'h8;
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 4;

  typedef enum logic [2:0] {
    I_IDLE = 3'b000,
    I_WAIT = 3'b001,
    I_START = 3'b010,
    I_HELD = 3'b011,
    I_STOP = 3'b100
  } scu_i2c_st_t;

  typedef struct packed {
    logic soft_reset_bit;
    logic sync_mode_select;
    logic i2c_mode_select;
    logic multi_master_select;
    logic transmitter_select;
    logic clock_phase_select;
    logic bit_order_select;
  } scu_cfg_t;

  typedef struct packed {
    logic start_request;
    logic bus_busy_flag;
    logic module_active_flag;
    logic tx_ready_flag;
    logic start_seen_flag;
    logic stop_seen_flag;
    logic nack_flag;
  } scu_flags_t;
endpackage : scu_pkg

// ---- rtl/scu_top.sv ----
/*
  serial communication unit: i2c start/stop generator and bus monitor,
  uart receiver, spi slave transmitter, with a small transmit fifo.
  assumes all pins are asynchronous to clock_i and config comes from
  logic on clock_i; spi clock polarity is idle low.
*/
module scu_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic flush_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] rd_q, rd_d, wr_q, wr_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  // honest full and empty from the fill count
  assign in_ready_o = (cnt_q != (AW+1)'(D));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_ready_i && out_valid_o;

  // pointer and count update
  always_comb begin
    rd_d = pop ? AW'(rd_q + 1'b1) : rd_q;
    wr_d = push ? AW'(wr_q + 1'b1) : wr_q;
    cnt_d = (AW+1)'(cnt_q + (AW+1)'(push) - (AW+1)'(pop));
    if (flush_i) begin
      rd_d = '0;
      wr_d = '0;
      cnt_d = '0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      rd_q <= '0;
      wr_q <= '0;
      cnt_q <= '0;
    end else begin
      rd_q <= rd_d;
      wr_q <= wr_d;
      cnt_q <= cnt_d;
    end
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end
endmodule : scu_fifo

// Contract
// RULE1: start issued at bus release, no free time
// RULE2: bus-free time 4.7us/1.3us not guaranteed
// RULE3: bus-free time runs stop to start
// RULE4: software checks busy flag before start
// RULE5: reset during receive poisons next byte
// RULE6: software toggles sync select before release
// RULE7: busy bus with start request waits idle
// RULE8: waiting, tx ready follows foreign clock
// RULE9: bytes written while waiting are discarded
// RULE10: software waits start request clear first
// RULE11: start hold fixed, fails above 50kHz
// RULE12: software keeps clock below 50kHz
// RULE13: start/stop/nack flags cleared by bus events
// RULE14: software masks local enables around global
// RULE15: phase one bytes after first offset
// RULE16: buffer write preloads shift register
// RULE17: software rewrites buffer each transfer
// RULE18: busy flag from start until stop
module scu_top
  import scu_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // control and status
  input wire scu_cfg_t cfg_i,
  input wire logic start_request_set_i,
  input wire logic stop_request_i,
  input wire logic [2:0] flag_clear_i,
  output scu_flags_t flags_o,
  // transmit holding buffer write
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_ready_o,
  // receive data
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic framing_error_o,
  // i2c pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe_o,
  output logic sda_o,
  output logic sda_oe_o,
  // uart and spi pins
  input wire logic rxd_i,
  input wire logic sclk_i,
  input wire logic cs_b_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o
);
  logic [5:0] sy1_q, sy2_q, sy3_q;
  scu_flags_t fl_q, fl_d;
  scu_i2c_st_t ist_q, ist_d;
  logic [9:0] icnt_q, icnt_d, ucnt_q, ucnt_d;
  logic [3:0] ubit_q, ubit_d, ebit_q, ebit_d;
  logic [2:0] sbit_q, sbit_d;
  logic [7:0] rxs_q, rxs_d, sh_q, sh_d, rx_data_q, rx_data_d;
  logic urx_q, urx_d, poison_q, poison_d, first_q, first_d, loaded_q, loaded_d;
  logic rx_valid_q, rx_valid_d, ferr_q, ferr_d;
  logic pop, stop_ev, fv, push;
  logic [7:0] fd;
  logic scl, sda, sta_det, sto_det, scl_rise, scl_fall, rxd_fall;
  logic spi_en, cs, smp, shf, msb, cpha;

  // one bit shift, direction by bit order
  function automatic logic [7:0] scu_shift(input logic [7:0] v, input logic m,
                                           input logic b);
    scu_shift = m ? {v[6:0], b} : {b, v[7:1]};
  endfunction : scu_shift

  scu_fifo #(.W(FIFO_W), .D(FIFO_D)) scu_fifo_inst (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .flush_i(cfg_i.soft_reset_bit),
    .in_valid_i(tx_valid_i),
    .in_data_i(tx_data_i),
    .in_ready_o(tx_ready_o),
    .out_valid_o(fv),
    .out_data_o(fd),
    .out_ready_i(pop)
  );

  // edges seen only from the second and third sync stages
  assign scl = sy2_q[0];
  assign sda = sy2_q[1];
  assign sta_det = scl && sy3_q[0] && !sda && sy3_q[1];
  assign sto_det = scl && sy3_q[0] && sda && !sy3_q[1];
  assign scl_rise = scl && !sy3_q[0];
  assign scl_fall = !scl && sy3_q[0];
  assign rxd_fall = !sy2_q[2] && sy3_q[2];
  assign cs = !sy2_q[4];
  assign spi_en = cfg_i.sync_mode_select && !cfg_i.i2c_mode_select;
  assign cpha = cfg_i.clock_phase_select;
  assign msb = cfg_i.bit_order_select;
  // phase one samples on the trailing edge and shifts on the leading one
  assign smp = cpha ? (!sy2_q[3] && sy3_q[3]) : (sy2_q[3] && !sy3_q[3]);
  assign shf = cpha ? (sy2_q[3] && !sy3_q[3]) : (!sy2_q[3] && sy3_q[3]);
  assign push = tx_valid_i && tx_ready_o;

  // next-state logic for all three protocol engines
  always_comb begin
    fl_d = fl_q;
    ist_d = ist_q;
    icnt_d = icnt_q;
    ucnt_d = ucnt_q;
    ubit_d = ubit_q;
    ebit_d = ebit_q;
    sbit_d = sbit_q;
    rxs_d = rxs_q;
    sh_d = sh_q;
    rx_data_d = rx_data_q;
    urx_d = urx_q;
    poison_d = poison_q;
    first_d = first_q;
    loaded_d = loaded_q;
    rx_valid_d = 1'b0;
    ferr_d = 1'b0;
    pop = 1'b0;
    stop_ev = 1'b0;
    // hardware clears on bus events, then software clears; sets come last
    if (sto_det) fl_d.start_seen_flag = 1'b0; // [RULE13]
    if (sta_det) begin
      fl_d.stop_seen_flag = 1'b0; // [RULE13]
      fl_d.nack_flag = 1'b0;
    end
    if (flag_clear_i[0]) fl_d.start_seen_flag = 1'b0;
    if (flag_clear_i[1]) fl_d.stop_seen_flag = 1'b0;
    if (flag_clear_i[2]) fl_d.nack_flag = 1'b0;
    if (push) fl_d.tx_ready_flag = 1'b0;
    if (sto_det) begin
      fl_d.bus_busy_flag = 1'b0; // [RULE18]
      fl_d.stop_seen_flag = 1'b1; // [RULE3]
    end
    if (sta_det) begin
      fl_d.bus_busy_flag = 1'b1; // [RULE18]
      fl_d.start_seen_flag = 1'b1;
      ebit_d = 4'h0;
    end else if (scl_rise && fl_q.bus_busy_flag) begin
      // ninth rising clock is the acknowledge slot
      ebit_d = (ebit_q == ACK_RISE) ? 4'h0 : 4'(ebit_q + 4'h1);
      if (ebit_q == ACK_RISE && sda) fl_d.nack_flag = 1'b1;
    end
    // i2c start and stop generation
    case (ist_q)
      I_IDLE: begin
        if (fl_q.start_request && cfg_i.sync_mode_select && cfg_i.i2c_mode_select) begin
          // no bus-free timer: the free time is left to software
          ist_d = fl_q.bus_busy_flag ? I_WAIT : I_START; // [RULE7] [RULE2]
          icnt_d = 10'h000;
        end
      end
      I_WAIT: begin
        if (scl_fall) fl_d.tx_ready_flag = 1'b1; // [RULE8]
        pop = fv; // [RULE9]
        if (!fl_q.bus_busy_flag) ist_d = I_START; // [RULE1]
      end
      I_START: begin
        // fixed hold, sized for a 100 kbps bus with slow clock only
        icnt_d = 10'(icnt_q + 10'h001);
        if (icnt_q == HD_CYC - 10'h001) begin // [RULE11]
          ist_d = I_HELD;
          fl_d.start_request = 1'b0;
          fl_d.tx_ready_flag = 1'b1;
        end
      end
      I_HELD: begin
        icnt_d = 10'h000;
        if (stop_request_i) ist_d = I_STOP;
      end
      I_STOP: begin
        icnt_d = 10'(icnt_q + 10'h001);
        if (icnt_q == SU_CYC - 10'h001) ist_d = I_IDLE;
      end
      default: ist_d = I_IDLE;
    endcase
    if (start_request_set_i) fl_d.start_request = 1'b1;
    // uart receiver, lsb first, one stop bit
    if (!urx_q) begin
      if (!cfg_i.sync_mode_select && rxd_fall) begin
        urx_d = 1'b1;
        ucnt_d = HALF_CYC;
        ubit_d = 4'h0;
      end
    end else if (ucnt_q != 10'h000) begin
      ucnt_d = 10'(ucnt_q - 10'h001);
    end else begin
      ucnt_d = BIT_CYC - 10'h001;
      ubit_d = 4'(ubit_q + 4'h1);
      if (ubit_q == 4'h0 && sy2_q[2]) urx_d = 1'b0;
      if (ubit_q != 4'h0 && ubit_q <= 4'h8) rxs_d = scu_shift(rxs_q, 1'b0, sy2_q[2]);
      if (ubit_q == 4'h9) begin
        stop_ev = 1'b1;
        urx_d = 1'b0;
        rx_data_d = rxs_q;
        rx_valid_d = 1'b1;
        ferr_d = !sy2_q[2] || poison_q; // [RULE5]
        poison_d = 1'b0;
      end
    end
    // spi slave shift engine
    if (!spi_en || !cs) begin
      sbit_d = 3'h0;
      first_d = 1'b1;
    end else begin
      // the shift edge after the last sample belongs to the next byte's load
      if (shf && sbit_q != 3'h0) sh_d = scu_shift(sh_q, msb, 1'b0);
      if (smp) begin
        rxs_d = scu_shift(rxs_q, msb, sy2_q[5]);
        sbit_d = 3'(sbit_q + 3'h1);
        if (sbit_q == 3'h7) begin
          rx_data_d = scu_shift(rxs_q, msb, sy2_q[5]);
          rx_valid_d = 1'b1;
          loaded_d = 1'b0;
          first_d = 1'b0;
        end
      end
    end
    // preload from the buffer; later bytes in phase one come in offset
    if (spi_en && !loaded_d && fv && sbit_d == 3'h0) begin
      pop = 1'b1; // [RULE16]
      loaded_d = 1'b1;
      sh_d = (cpha && !first_d) ? scu_shift(fd, msb, 1'b0) : fd; // [RULE15]
    end
    fl_d.module_active_flag = urx_d || (ist_d != I_IDLE) || (spi_en && cs);
    // soft reset: receiver poison survives until sync select is toggled or the next byte's stop bit
    if (cfg_i.soft_reset_bit) begin
      if (urx_q) poison_d = 1'b1; // [RULE5]
      if (cfg_i.sync_mode_select) poison_d = 1'b0; // [RULE6]
      fl_d = '0;
      ist_d = I_IDLE;
      urx_d = 1'b0;
      sbit_d = 3'h0;
      loaded_d = 1'b0;
      first_d = 1'b1;
      rx_valid_d = 1'b0;
      ferr_d = 1'b0;
    end
  end

  // registers; synchroniser first stage only feeds the second
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      sy1_q <= SYNC_RST;
      sy2_q <= SYNC_RST;
      sy3_q <= SYNC_RST;
      fl_q <= '0;
      ist_q <= I_IDLE;
      icnt_q <= 10'h000;
      ucnt_q <= 10'h000;
      ubit_q <= 4'h0;
      ebit_q <= 4'h0;
      sbit_q <= 3'h0;
      rxs_q <= 8'h00;
      sh_q <= 8'h00;
      rx_data_q <= 8'h00;
      urx_q <= 1'b0;
      poison_q <= 1'b0;
      first_q <= 1'b1;
      loaded_q <= 1'b0;
      rx_valid_q <= 1'b0;
      ferr_q <= 1'b0;
    end else begin
      sy1_q <= {mosi_i, cs_b_i, sclk_i, rxd_i, sda_i, scl_i};
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
      fl_q <= fl_d;
      ist_q <= ist_d;
      icnt_q <= icnt_d;
      ucnt_q <= ucnt_d;
      ubit_q <= ubit_d;
      ebit_q <= ebit_d;
      sbit_q <= sbit_d;
      rxs_q <= rxs_d;
      sh_q <= sh_d;
      rx_data_q <= rx_data_d;
      urx_q <= urx_d;
      poison_q <= poison_d;
      first_q <= first_d;
      loaded_q <= loaded_d;
      rx_valid_q <= rx_valid_d;
      ferr_q <= ferr_d;
    end
  end

  // outputs; open-drain lines only ever pull low
  assign flags_o = fl_q;
  assign rx_data_o = rx_data_q;
  assign rx_valid_o = rx_valid_q;
  assign framing_error_o = ferr_q;
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = (ist_q == I_HELD);
  assign sda_oe_o = (ist_q == I_START) || (ist_q == I_HELD) || (ist_q == I_STOP);
  assign miso_o = msb ? sh_q[7] : sh_q[0];
  assign miso_oe_o = spi_en && cs;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  a_busy_from_start: assert property (sta_det && !cfg_i.soft_reset_bit
    |=> fl_q.bus_busy_flag [*2]) else $error("busy flag not set by start"); // [RULE18]
  a_wait_on_busy: assert property (ist_q == I_IDLE && fl_q.start_request &&
    fl_q.bus_busy_flag && cfg_i.sync_mode_select && cfg_i.i2c_mode_select &&
    !cfg_i.soft_reset_bit |=> ist_q == I_WAIT) else $error("no wait on busy"); // [RULE7]
  a_start_on_free: assert property (ist_q == I_WAIT && !fl_q.bus_busy_flag &&
    !cfg_i.soft_reset_bit |=> ist_q == I_START ##1 sda_oe_o)
    else $error("start not issued at release"); // [RULE1]
  a_wait_discard: assert property (ist_q == I_WAIT && fv |-> pop)
    else $error("byte kept while waiting"); // [RULE9]
  a_tx_ready_wait: assert property (ist_q == I_WAIT && scl_fall && !push &&
    !cfg_i.soft_reset_bit |=> fl_q.tx_ready_flag) else $error("tx ready not set"); // [RULE8]
  a_start_hold: assert property ($fell(ist_q == I_START) && !$past(cfg_i.soft_reset_bit)
    |-> $past(icnt_q) == HD_CYC - 10'h001 && !fl_q.start_request)
    else $error("start hold length wrong"); // [RULE11]
  a_flag_hw_clear: assert property (sto_det && !cfg_i.soft_reset_bit
    |=> !fl_q.start_seen_flag && fl_q.stop_seen_flag) else $error("flags not updated"); // [RULE13]
  a_poison_frame: assert property (stop_ev && poison_q && !cfg_i.soft_reset_bit
    |=> framing_error_o && rx_valid_o && !poison_q) else $error("no framing error"); // [RULE5]
  a_phase_offset: assert property (pop && spi_en && cpha && !first_d &&
    !cfg_i.soft_reset_bit |=> sh_q == scu_shift($past(fd), msb, 1'b0))
    else $error("phase one byte not offset"); // [RULE15]
  a_preload: assert property (pop && spi_en && !cpha && !cfg_i.soft_reset_bit
    |=> sh_q == $past(fd) && loaded_q) else $error("preload failed"); // [RULE16]

  c_wait_start: cover property (ist_q == I_WAIT ##[1:1000] ist_q == I_START);
  c_uart_byte: cover property (rx_valid_o && !framing_error_o && !cfg_i.sync_mode_select);
  c_poison: cover property (framing_error_o && !cfg_i.sync_mode_select);
  c_spi_two: cover property (spi_en && cpha && pop && !first_d);
endmodule : scu_top

// ---- verification/scu_far_model.sv ----
/*
  far-side model: another i2c master, a uart sender and an spi master.
  assumes the bench ands the released i2c lines with the unit's pulls.
*/
module scu_far_model
  import scu_pkg::*;
(
  // i2c lines, 1 = released
  output logic scl_rel_o,
  output logic sda_rel_o,
  // uart and spi
  output logic rxd_o,
  output logic sclk_o,
  output logic cs_b_o,
  output logic mosi_o,
  input wire logic miso_i
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT_NS = int'(BIT_CYC) * CLK_PERIOD_NS;
  // idle: lines released, uart high, spi clock still
  initial begin
    {scl_rel_o, sda_rel_o, rxd_o, cs_b_o} = 4'hf;
    {sclk_o, mosi_o} = 2'h0;
  end
  // free time kept before our start; the unit itself does not keep it
  task i2c_start();
    #(T_BUF_STD_NS);
    sda_rel_o = 1'b0;
    #1000;
  endtask : i2c_start
  // one clock low pulse while holding data low
  // foreign clock kept under 50 kHz, as repeated starts need
  task i2c_pulse();
    scl_rel_o = 1'b0;
    #12000;
    scl_rel_o = 1'b1;
    #12000;
  endtask : i2c_pulse
  task i2c_stop();
    sda_rel_o = 1'b1;
  endtask : i2c_stop
  // 8n1, lsb first
  task uart_tx(input logic [7:0] d);
    rxd_o = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < 8; i++) begin
      rxd_o = d[i];
      #(BIT_NS);
    end
    rxd_o = 1'b1;
    #(BIT_NS);
  endtask : uart_tx
  // 16 clocks of 200 ns; duty skewed so the sampling half is the long one
  task spi_xfer(input logic cpha, output logic [15:0] got);
    got = 16'h0000;
    cs_b_o = 1'b0;
    #400;
    for (int i = 0; i < 16; i++) begin
      if (!cpha) got = {got[14:0], miso_i};
      sclk_o = 1'b1;
      #(cpha ? 140 : 60);
      if (cpha) got = {got[14:0], miso_i};
      sclk_o = 1'b0;
      mosi_o = ~mosi_o;
      #(cpha ? 60 : 140);
    end
    #200;
    cs_b_o = 1'b1;
  endtask : spi_xfer
endmodule : scu_far_model

// ---- verification/serial_comm_unit_corner_cases_tb.sv ----
/*
  self-checking bench for scu_top: i2c start, bus wait, uart, spi slave.
  assumes scu_far_model drives the pins; clock 40 mhz.
*/
module serial_comm_unit_corner_cases_tb
  import scu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i, rst_b_i, start_request_set_i, stop_request_i, tx_valid_i;
  logic tx_ready_o, rx_valid_o, framing_error_o, miso_o, miso_oe_o;
  logic scl_o, scl_oe_o, sda_o, sda_oe_o, scl_rel, sda_rel, rxd, sclk, cs_b, mosi;
  logic fe_last;
  logic [2:0] flag_clear_i;
  logic [7:0] tx_data_i, rx_data_o, rx_last;
  logic [15:0] got;
  scu_cfg_t cfg_i;
  scu_flags_t flags_o;
  int error_cnt, compares, rx_cnt;
  // open-drain wires, pulled up
  wire scl_w = (scl_oe_o ? scl_o : 1'b1) & scl_rel;
  wire sda_w = (sda_oe_o ? sda_o : 1'b1) & sda_rel;

  scu_top scu_top_inst (.clock_i(clock_i), .rst_b_i(rst_b_i), .cfg_i(cfg_i),
    .start_request_set_i(start_request_set_i), .stop_request_i(stop_request_i),
    .flag_clear_i(flag_clear_i), .flags_o(flags_o), .tx_valid_i(tx_valid_i),
    .tx_data_i(tx_data_i), .tx_ready_o(tx_ready_o), .rx_data_o(rx_data_o),
    .rx_valid_o(rx_valid_o), .framing_error_o(framing_error_o), .scl_i(scl_w),
    .sda_i(sda_w), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .rxd_i(rxd), .sclk_i(sclk), .cs_b_i(cs_b), .mosi_i(mosi),
    .miso_o(miso_o), .miso_oe_o(miso_oe_o));
  scu_far_model scu_far_model_inst (.scl_rel_o(scl_rel), .sda_rel_o(sda_rel),
    .rxd_o(rxd), .sclk_o(sclk), .cs_b_o(cs_b), .mosi_o(mosi), .miso_i(miso_o));

  initial begin
    clock_i = 1'b0;
    forever #(CLK_PERIOD_NS / 2.0) clock_i = ~clock_i;
  end
  // received bytes, caught since the valid pulse lasts one cycle
  always @(posedge clock_i) begin
    if (rx_valid_o === 1'b1) begin
      rx_cnt <= rx_cnt + 1;
      rx_last <= rx_data_o;
      fe_last <= framing_error_o;
    end
  end

  task tally_and_finish();
    $display("counts: %0d compares, %0d mismatches", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  task chk_flag(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk_flag
  task chk_byte(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk_byte
  task settle(input int n);
    repeat (n) @(negedge clock_i);
  endtask : settle
  // one-cycle strobe of {tx_valid, stop, start}
  task strobe(input logic [2:0] sel, input logic [7:0] d);
    @(posedge clock_i);
    {tx_valid_i, stop_request_i, start_request_set_i} <= sel;
    tx_data_i <= d;
    @(posedge clock_i);
    {tx_valid_i, stop_request_i, start_request_set_i} <= 3'h0;
  endtask : strobe
  task wait_started();
    repeat (300) if (flags_o.start_request !== 1'b0) @(negedge clock_i);
    chk_flag(flags_o.start_request, 1'b0);
  endtask : wait_started
  task stop_and_wait();
    strobe(3'h2, 8'h00);
    repeat (300) if (sda_oe_o !== 1'b0) @(negedge clock_i);
    chk_flag(sda_oe_o, 1'b0);
    settle(6);
  endtask : stop_and_wait
  task uart_check(input logic [7:0] d, input logic fe);
    int n;
    n = rx_cnt;
    scu_far_model_inst.uart_tx(d);
    settle(2);
    chk_flag(rx_cnt != n, 1'b1);
    chk_flag(fe_last, fe);
    if (!fe) chk_byte(rx_last, d);
  endtask : uart_check
  // soft reset in mid-byte, optionally toggling sync select while held
  task uart_abort(input logic fix);
    fork
      scu_far_model_inst.uart_tx(8'hc3);
      begin
        #30000;
        chk_flag(flags_o.module_active_flag, 1'b1);
        @(posedge clock_i) cfg_i <= 7'h40;
        if (fix) begin
          @(posedge clock_i) cfg_i <= 7'h60;
          @(posedge clock_i) cfg_i <= 7'h40;
        end
      end
    join
    @(posedge clock_i) cfg_i <= 7'h00;
  endtask : uart_abort

  // watchdog, tests take about 0.5 ms
  initial begin
    #2_000_000;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    {rst_b_i, start_request_set_i, stop_request_i, tx_valid_i} = 4'h0;
    {flag_clear_i, tx_data_i} = 11'h000;
    cfg_i = 7'h3d;
    error_cnt = 0;
    compares = 0;
    rx_cnt = 0;
    repeat (4) @(posedge clock_i);
    rst_b_i <= 1'b1;
    settle(4);
    chk_byte(8'(flags_o), 8'h00);
    $display("test reset done");
    // start on a free bus
    strobe(3'h1, 8'h00);
    settle(2);
    chk_flag(sda_oe_o, 1'b1);
    wait_started();
    chk_flag(scl_oe_o, 1'b1);
    chk_flag(flags_o.bus_busy_flag, 1'b1);
    chk_flag(flags_o.start_seen_flag, 1'b1);
    stop_and_wait();
    chk_flag(flags_o.bus_busy_flag, 1'b0);
    chk_flag(flags_o.start_seen_flag, 1'b0);
    chk_flag(flags_o.stop_seen_flag, 1'b1);
    @(posedge clock_i) flag_clear_i <= 3'h2; // clear with no bus event due
    @(posedge clock_i) flag_clear_i <= 3'h0;
    settle(2);
    chk_flag(flags_o.stop_seen_flag, 1'b0);
    $display("test free start done");
    // start requested while another master holds the bus
    scu_far_model_inst.i2c_start();
    chk_flag(flags_o.bus_busy_flag, 1'b1);
    strobe(3'h1, 8'h00); // no busy check here on purpose
    settle(10);
    chk_flag(sda_oe_o, 1'b0);
    // more bytes than the fifo holds: only discarding keeps it open
    repeat (5) strobe(3'h4, 8'h5a);
    settle(4);
    chk_flag(tx_ready_o, 1'b1);
    chk_flag(flags_o.tx_ready_flag, 1'b0);
    scu_far_model_inst.i2c_pulse();
    chk_flag(flags_o.tx_ready_flag, 1'b1);
    scu_far_model_inst.i2c_stop();
    repeat (12) if (sda_oe_o !== 1'b1) @(negedge clock_i);
    chk_flag(sda_oe_o, 1'b1);
    wait_started();
    stop_and_wait();
    $display("test busy bus done");
    // uart: fifo never drains here, so it fills
    @(posedge clock_i) cfg_i <= 7'h00;
    repeat (5) strobe(3'h4, 8'h11);
    settle(1);
    chk_flag(tx_ready_o, 1'b0);
    uart_check(8'h5a, 1'b0);
    uart_abort(1'b0);
    chk_flag(tx_ready_o, 1'b1);
    uart_check(8'h3c, 1'b1);
    uart_abort(1'b1);
    uart_check(8'h96, 1'b0);
    $display("test uart done");
    // spi slave, msb first, both clock phases
    @(posedge clock_i) cfg_i <= 7'h21;
    strobe(3'h4, 8'ha5);
    strobe(3'h4, 8'h3c);
    settle(1);
    scu_far_model_inst.spi_xfer(1'b0, got);
    chk_byte(got[15:8], 8'ha5);
    chk_byte(got[7:0], 8'h3c);
    @(posedge clock_i) cfg_i <= 7'h23;
    strobe(3'h4, 8'ha5);
    strobe(3'h4, 8'h3c);
    settle(1);
    scu_far_model_inst.spi_xfer(1'b1, got);
    chk_byte(got[15:8], 8'ha5);
    // second byte arrives one bit early, msb first: 3c becomes 78
    chk_byte(got[7:0], 8'h78);
    $display("test spi done");
    tally_and_finish();
  end
endmodule : serial_comm_unit_corner_cases_tb
